// *** design/power_off_pkg.sv ***
package power_off_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int KEY_MSB = 31;
  localparam int KEY_LSB = 24;
  localparam int CMD_BIT = 0;
  localparam int EDGE_LSB = 0;
  localparam int EDGE_W = 2;
  localparam int COUNT_LSB = 4;
  localparam int COUNT_W = 4;
  localparam int TIMER_EN_BIT = 16;
  localparam int PIN_FLAG_BIT = 0;
  localparam int TIMER_FLAG_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // values and counts
  localparam logic [7:0] COMMAND_KEY = 8'ha5;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0003;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam int DEBOUNCE_UNIT = 16;
  localparam int CMD_DELAY_CYCLES = 2;

  ////////////////////////////////////////////////////////////////////////////
  // encodings follow declaration order: none, rise, fall, any
  typedef enum logic [1:0] {edge_none, edge_rise, edge_fall, edge_any} wake_edge_t;

  typedef enum logic {deb_idle, deb_count} deb_state_t;

endpackage

// *** design/power_off_unit.sv ***
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module power_off_unit #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_in0,
  input wire logic timer_alarm,
  output logic supply_off_out,
  output logic irq
);
  import power_off_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  wake_edge_t wake_edge_select;
  wake_edge_t next_wake_edge_select;
  logic [COUNT_W-1:0] wake_debounce_count;
  logic [COUNT_W-1:0] next_wake_debounce_count;
  logic timer_alarm_wake_enable;
  logic next_timer_alarm_wake_enable;
  logic pin_wake_seen;
  logic next_pin_wake_seen;
  logic timer_alarm_wake_seen;
  logic next_timer_alarm_wake_seen;
  logic [1:0] irq_status;
  logic [1:0] next_irq_status;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_mask;
  logic [31:0] next_prdata;
  logic [CMD_DELAY_CYCLES-1:0] cmd_pipe;
  logic [CMD_DELAY_CYCLES-1:0] next_cmd_pipe;
  logic next_supply_off_out;
  logic alarm_a;
  logic alarm_b;
  logic alarm_prev;

  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic rd_status;
  logic cmd_valid;
  logic pin_wake;
  logic timer_rise;
  logic timer_wake;
  logic [1:0] irq_clear;
  logic [31:0] read_mux;
  logic [ADDR_W-1:0] addr;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; every access completes without wait states
  assign addr = paddr;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign pready = 1'b1;

  always_comb begin
    case (addr)
      ADDR_W'(ADDR_COMMAND),
      ADDR_W'(ADDR_CONFIG),
      ADDR_W'(ADDR_STATUS),
      ADDR_W'(ADDR_IRQ_STATUS),
      ADDR_W'(ADDR_IRQ_MASK): mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = access & ~mapped;
  assign rd_status = access & ~pwrite & (addr == ADDR_W'(ADDR_STATUS));

  always_comb begin
    read_mux = 32'h0000_0000;
    case (addr)
      ADDR_W'(ADDR_CONFIG): begin
        read_mux[EDGE_LSB +: EDGE_W] = wake_edge_select;
        read_mux[COUNT_LSB +: COUNT_W] = wake_debounce_count;
        read_mux[TIMER_EN_BIT] = timer_alarm_wake_enable;
      end
      ADDR_W'(ADDR_STATUS): begin
        read_mux[PIN_FLAG_BIT] = pin_wake_seen;
        read_mux[TIMER_FLAG_BIT] = timer_alarm_wake_seen;
      end
      ADDR_W'(ADDR_IRQ_STATUS): read_mux[1:0] = irq_status;
      ADDR_W'(ADDR_IRQ_MASK): read_mux[1:0] = irq_mask;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake sources
  wake_debounce #(
    .CNT_W(COUNT_W),
    .UNIT(DEBOUNCE_UNIT)
  ) u_wake_debounce (
    .pclk(pclk),
    .presetn(presetn),
    .wake_in(wake_in0),
    .edge_sel(wake_edge_select),
    .count_sel(wake_debounce_count),
    .wake_pulse(pin_wake)
  );

  assign timer_rise = alarm_b & ~alarm_prev;
  // an alarm flag already high at shutdown gives no edge and no wake
  assign timer_wake = timer_rise & timer_alarm_wake_enable;

  ////////////////////////////////////////////////////////////////////////////
  // register next values
  always_comb begin
    next_wake_edge_select = wake_edge_select;
    next_wake_debounce_count = wake_debounce_count;
    next_timer_alarm_wake_enable = timer_alarm_wake_enable;
    next_irq_mask = irq_mask;
    next_prdata = prdata;
    irq_clear = 2'b00;
    if (wr && addr == ADDR_W'(ADDR_CONFIG)) begin
      if (pstrb[0]) begin
        next_wake_edge_select = wake_edge_t'(pwdata[EDGE_LSB +: EDGE_W]);
        next_wake_debounce_count = pwdata[COUNT_LSB +: COUNT_W];
      end
      if (pstrb[2]) begin
        next_timer_alarm_wake_enable = pwdata[TIMER_EN_BIT];
      end
    end
    if (wr && addr == ADDR_W'(ADDR_IRQ_MASK) && pstrb[0]) begin
      next_irq_mask = pwdata[1:0];
    end
    if (wr && addr == ADDR_W'(ADDR_IRQ_STATUS) && pstrb[0]) begin
      irq_clear = pwdata[1:0];
    end
    // data is caught in setup; only the caught bits are cleared on read
    if (setup && !pwrite) begin
      next_prdata = read_mux;
    end
    next_pin_wake_seen = (pin_wake_seen & ~(rd_status & prdata[PIN_FLAG_BIT]))
      | pin_wake;
    next_timer_alarm_wake_seen = (timer_alarm_wake_seen
      & ~(rd_status & prdata[TIMER_FLAG_BIT])) | timer_wake;
    next_irq_status = (irq_status & ~irq_clear) | {timer_wake, pin_wake};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_edge_select <= wake_edge_t'(CONFIG_RESET[EDGE_LSB +: EDGE_W]);
      wake_debounce_count <= CONFIG_RESET[COUNT_LSB +: COUNT_W];
      timer_alarm_wake_enable <= CONFIG_RESET[TIMER_EN_BIT];
      pin_wake_seen <= 1'b0;
      timer_alarm_wake_seen <= 1'b0;
      irq_status <= 2'b00;
      irq_mask <= IRQ_MASK_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      wake_edge_select <= next_wake_edge_select;
      wake_debounce_count <= next_wake_debounce_count;
      timer_alarm_wake_enable <= next_timer_alarm_wake_enable;
      pin_wake_seen <= next_pin_wake_seen;
      timer_alarm_wake_seen <= next_timer_alarm_wake_seen;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      prdata <= next_prdata;
    end
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // shutdown path
  always_comb begin
    cmd_valid = wr && addr == ADDR_W'(ADDR_COMMAND) && pstrb[3] && pstrb[0]
      && pwdata[KEY_MSB:KEY_LSB] == COMMAND_KEY
      && pwdata[CMD_BIT];
    next_cmd_pipe = {cmd_pipe[CMD_DELAY_CYCLES-2:0], cmd_valid};
    next_supply_off_out = supply_off_out;
    if (cmd_pipe[CMD_DELAY_CYCLES-1]) begin
      // a fresh command beats a wake in the same cycle
      next_supply_off_out = 1'b1;
    end else if (pin_wake || timer_wake) begin
      next_supply_off_out = 1'b0;
    end
  end

  // free-running clock, no enable anywhere in the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pipe <= '0;
      supply_off_out <= 1'b0;
      alarm_a <= 1'b0;
      alarm_b <= 1'b0;
      alarm_prev <= 1'b0;
    end else begin
      cmd_pipe <= next_cmd_pipe;
      supply_off_out <= next_supply_off_out;
      alarm_a <= timer_alarm;
      alarm_b <= alarm_a;
      alarm_prev <= alarm_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // an output change at edge E+2 is first sampled at E+3
  a_cmd_two_cycles: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_valid && cmd_pipe == '0 && !supply_off_out)
      |-> ##1 !supply_off_out ##1 !supply_off_out ##1 supply_off_out)
    else $error("shutdown command not seen two cycles after write");

  a_cmd_asserts: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && addr == ADDR_W'(ADDR_COMMAND) && pstrb == 4'hf && pwdata[CMD_BIT]
      && pwdata[KEY_MSB:KEY_LSB] == COMMAND_KEY) |-> ##3 supply_off_out)
    else $error("valid shutdown command did not assert output");

  a_bad_key_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && addr == ADDR_W'(ADDR_COMMAND) && pwdata[KEY_MSB:KEY_LSB] != COMMAND_KEY
      && cmd_pipe == '0 && !supply_off_out) |-> ##3 !supply_off_out)
    else $error("command with wrong key took effect");

  a_zero_cmd_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && addr == ADDR_W'(ADDR_COMMAND) && !pwdata[CMD_BIT]
      && cmd_pipe == '0 && !supply_off_out) |-> ##3 !supply_off_out)
    else $error("command bit zero took effect");

  a_timer_release: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_rise && timer_alarm_wake_enable && !cmd_pipe[CMD_DELAY_CYCLES-1])
      |=> !supply_off_out)
    else $error("enabled timer alarm did not release output");

  a_timer_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (supply_off_out && !timer_alarm_wake_enable && !pin_wake) |=> supply_off_out)
    else $error("disabled timer alarm released output");

  a_off_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (supply_off_out && !pin_wake && !timer_wake) |=> supply_off_out)
    else $error("output released without a wake cause");

  a_pin_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    pin_wake |=> pin_wake_seen && irq_status[0])
    else $error("pin wake not recorded");

  a_timer_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    timer_wake |=> timer_alarm_wake_seen && irq_status[1])
    else $error("timer wake not recorded");

  a_status_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && addr == ADDR_W'(ADDR_STATUS) && pin_wake_seen)
      ##1 (rd_status && !pin_wake) |=> !pin_wake_seen)
    else $error("status read did not clear pin flag");

  a_alarm_edge_two_sync: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(timer_alarm) ##1 timer_alarm [*3]) |-> ##0 $past(timer_rise))
    else $error("timer alarm edge not detected after synchronisation");

  a_pin_release: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_wake && !cmd_pipe[CMD_DELAY_CYCLES-1]) |=> !supply_off_out)
    else $error("recognised pin wake did not release output");

  a_mode_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_edge_select == edge_none) |-> !pin_wake)
    else $error("pin wake recognised with detection off");

  a_timer_flag_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && addr == ADDR_W'(ADDR_STATUS) && timer_alarm_wake_seen)
      ##1 (rd_status && !timer_wake) |=> !timer_alarm_wake_seen)
    else $error("status read did not clear timer flag");

  a_disabled_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_rise && !timer_alarm_wake_enable && !timer_alarm_wake_seen)
      |=> !timer_alarm_wake_seen)
    else $error("disabled timer alarm was recorded");

  // a fresh rise needs both sync flops before it counts as an edge
  a_alarm_not_early: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(timer_alarm) && !alarm_a && !alarm_b && !alarm_prev)
      |-> !timer_rise ##1 !timer_rise)
    else $error("timer alarm edge seen before synchronisation");

  a_off_needs_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(supply_off_out) |-> $past(cmd_pipe[CMD_DELAY_CYCLES-1]))
    else $error("output asserted without a keyed command");

endmodule // power_off_unit

// *** design/wake_debounce.sv ***
`timescale 1ns/1ps
module wake_debounce #(
  parameter int CNT_W = power_off_pkg::COUNT_W,
  parameter int UNIT = power_off_pkg::DEBOUNCE_UNIT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wake_in,
  input wire power_off_pkg::wake_edge_t edge_sel,
  input wire logic [CNT_W-1:0] count_sel,
  output logic wake_pulse
);
  import power_off_pkg::*;

  localparam int TGT_W = CNT_W + $clog2(UNIT);

  logic sync_a;
  logic sync_b;
  logic prev;
  deb_state_t state;
  deb_state_t next_state;
  logic [TGT_W-1:0] count;
  logic [TGT_W-1:0] next_count;
  logic [TGT_W-1:0] target;
  logic change;
  logic qualify;

  ////////////////////////////////////////////////////////////////////////////
  assign target = TGT_W'(count_sel) * TGT_W'(UNIT);

  always_comb begin
    change = sync_b ^ prev;
    case (edge_sel)
      edge_none: qualify = 1'b0;
      edge_rise: qualify = change & sync_b;
      edge_fall: qualify = change & ~sync_b;
      edge_any: qualify = change;
      default: qualify = 1'b0;
    endcase
    next_state = state;
    next_count = count;
    wake_pulse = 1'b0;
    if (qualify) begin
      if (target == '0) begin
        wake_pulse = 1'b1;
        next_state = deb_idle;
        next_count = '0;
      end else begin
        next_state = deb_count;
        next_count = TGT_W'(1);
      end
    end else if (change) begin
      // a bounce that is not itself a qualifying edge abandons the count and returns to idle
      next_state = deb_idle;
      next_count = '0;
    end else if (state == deb_count) begin
      if (edge_sel == edge_none) begin
        next_state = deb_idle;
        next_count = '0;
      end else if (count == target) begin
        wake_pulse = 1'b1;
        next_state = deb_idle;
        next_count = '0;
      end else begin
        next_count = count + TGT_W'(1);
      end
    end
  end

  // input is resynchronised even though it is nominally synchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
      state <= deb_idle;
      count <= '0;
    end else begin
      sync_a <= wake_in;
      sync_b <= sync_a;
      prev <= sync_b;
      state <= next_state;
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_bounce_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (state == deb_count && change && !qualify) |=> (state == deb_idle && count == '0))
    else $error("debounce count survived an input change");

  a_fire_at_target: assert property (@(posedge pclk) disable iff (!presetn)
    (state == deb_count && !change && edge_sel != edge_none && count == target)
      |-> wake_pulse)
    else $error("wake not fired at programmed count");

  a_no_early_fire: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_pulse && !qualify) |-> (count == target))
    else $error("wake fired before programmed count");

endmodule // wake_debounce

// *** testbench/supply_partner.sv ***
`timescale 1ns/1ps
module supply_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic press,
  input wire logic alarm_req,
  input wire logic supply_off_out,
  output logic wake_in0,
  output logic timer_alarm,
  output logic rails_on
);
  // button and alarm flag pass straight through; the bench owns their timing
  assign wake_in0 = press;
  assign timer_alarm = alarm_req;
  ////////////////////////////////////////////////////////////////////////////
  // regulator drops rails a clock after the off request, no soft start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rails_on <= 1'b1;
    end else begin
      rails_on <= !supply_off_out;
    end
  end
endmodule // supply_partner

// *** testbench/test_power_off_unit.sv ***
`timescale 1ns/1ps
module test_power_off_unit;
  import power_off_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, err, supply_off_out, irq, wake_in0, timer_alarm;
  logic press = 1'b0;
  logic [3:0] pstrb = 4'hf;
  logic rails;
  logic alarm_req = 1'b0;
  int errors = 0;
  int checked = 0;
  int seed = 7;
  int n;

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  power_off_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_in0(wake_in0), .timer_alarm(timer_alarm),
    .supply_off_out(supply_off_out), .irq(irq));
  supply_partner far_side (.pclk(pclk), .presetn(presetn), .press(press),
    .alarm_req(alarm_req), .supply_off_out(supply_off_out), .wake_in0(wake_in0),
    .timer_alarm(timer_alarm), .rails_on(rails));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic final_report();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ends at the access edge; pready sampled there, never assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask

  function automatic logic [31:0] cfg_exp(input logic [31:0] w);
    return w & 32'h0001_00f3;
  endfunction

  // edges from input change to release: two sync flops, the output flop and the count
  function automatic int pin_delay(input int cnt);
    return cnt * DEBOUNCE_UNIT + 3;
  endfunction

  task automatic shut();
    apb(1'b1, ADDR_COMMAND, {COMMAND_KEY, 23'h0, 1'b1});
    cyc(CMD_DELAY_CYCLES - 1);
    chk(supply_off_out, 1'b0, "off too early");
    cyc(1);
    chk(supply_off_out, 1'b1, "off missing");
    cyc(1);
    chk(rails, 1'b0, "rails still on");
  endtask

  task automatic pin_wake(input logic lvl, input int cnt);
    @(posedge pclk);
    press <= lvl;
    cyc(pin_delay(cnt) - 1);
    chk(supply_off_out, 1'b1, "wake too early");
    cyc(1);
    chk(supply_off_out, 1'b0, "wake missing");
  endtask

  function automatic logic [31:0] cfg(input int m, input int cnt, input logic ten);
    logic [31:0] w;
    w = 32'h0;
    w[1:0] = m[1:0];
    w[7:4] = cnt[3:0];
    w[TIMER_EN_BIT] = ten;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    chk(supply_off_out, 1'b0, "reset out");
    presetn <= 1'b1;
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd, CONFIG_RESET, "config reset");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0, "status reset");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      apb(1'b1, ADDR_CONFIG, v);
      apb(1'b0, ADDR_CONFIG, 32'h0);
      chk(rd, cfg_exp(v), "config readback");
    end
    v = $random(seed);
    if (v[31:24] == COMMAND_KEY) v[31:24] = 8'h5a;
    v[0] = 1'b1;
    apb(1'b1, ADDR_COMMAND, v);
    apb(1'b1, ADDR_COMMAND, {COMMAND_KEY, 24'h0});
    pstrb <= 4'h1;
    apb(1'b1, ADDR_COMMAND, {COMMAND_KEY, 23'h0, 1'b1});
    pstrb <= 4'hf;
    cyc(4);
    chk(supply_off_out, 1'b0, "bad command acted");
    apb(1'b0, 8'h14, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    // modes high to low so mode off, which never releases, comes last
    for (int m = 3; m >= 0; m--) begin
      n = {$random(seed)} % 3;
      apb(1'b1, ADDR_CONFIG, cfg(m, n, 1'b0));
      @(posedge pclk);
      press <= (m >= 2);
      cyc(60);
      shut();
      apb(1'b0, ADDR_STATUS, 32'h0);
      if (m == 0) begin
        @(posedge pclk);
        press <= 1'b1;
        cyc(60);
        chk(supply_off_out, 1'b1, "mode off woke");
      end else begin
        pin_wake(m == 1, n);
      end
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[PIN_FLAG_BIT], m != 0, "pin flag");
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h0, "flag not cleared");
    end
    // glitches shorter than the count must not release
    apb(1'b1, ADDR_CONFIG, cfg(1, 1, 1'b0));
    @(posedge pclk);
    press <= 1'b0;
    cyc(40);
    @(posedge pclk);
    press <= 1'b1;
    repeat (8) @(posedge pclk);
    press <= 1'b0;
    cyc(40);
    chk(supply_off_out, 1'b1, "glitch woke");
    pin_wake(1'b1, 1);
    apb(1'b1, ADDR_CONFIG, cfg(0, 0, 1'b0));
    shut();
    apb(1'b0, ADDR_STATUS, 32'h0);
    @(posedge pclk);
    alarm_req <= 1'b1;
    cyc(10);
    chk(supply_off_out, 1'b1, "disabled alarm woke");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[TIMER_FLAG_BIT], 1'b0, "disabled alarm flagged");
    alarm_req <= 1'b0;
    apb(1'b1, ADDR_CONFIG, cfg(0, 0, 1'b1));
    cyc(5);
    @(posedge pclk);
    alarm_req <= 1'b1;
    cyc(2);
    chk(supply_off_out, 1'b1, "alarm too early");
    cyc(1);
    chk(supply_off_out, 1'b0, "alarm missing");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[TIMER_FLAG_BIT], 1'b1, "timer flag");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0, "timer flag kept");
    // interrupt: both causes pending, mask and clear one at a time
    chk(irq, 1'b0, "irq unmasked");
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    #1;
    chk(irq, 1'b1, "irq pin");
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    #1;
    chk(irq, 1'b0, "irq pin clear");
    apb(1'b1, ADDR_IRQ_MASK, 32'h3);
    #1;
    chk(irq, 1'b1, "irq timer");
    apb(1'b1, ADDR_IRQ_STATUS, 32'h3);
    #1;
    chk(irq, 1'b0, "irq timer clear");
    final_report();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    final_report();
  end
endmodule // test_power_off_unit
